//--- core/bib_regs.sv
// bus information block register bank with ahb-lite access
`timescale 1ns/10ps

// Summary of operation
// - header register is config ROM quadlet one at FFFF F000 0400h.
// - header register at 18h is read/write, upper half resets to zero.
// - with serial ROM present, its checksum loads header bits 15..0.
// - without serial ROM the checksum bits reset to zero and change only by host write.
// - register at 1Ch is read-only, always returns 3133 3934h.
// - options register at 20h is bus information block quadlet two.
// - options bit 31 read/write, resource manager capable.
// - options bit 30 read/write, cycle master capable.
// - options bit 29 read/write, isochronous support capable.
// - options bits 2..0 read-only, return 010.
module bib_regs
(
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic srom_present_i,
	input wire logic srom_crc_valid_i,
	input wire logic [15:0] srom_crc_i,
	input wire logic link_active_i,
	input wire logic cfg_req_i,
	input wire logic [47:0] cfg_addr_i,
	output logic cfg_ack_o,
	output logic cfg_hit_o,
	output logic [31:0] cfg_data_o
);
	logic [1:0] rst_sync_ff;
	logic rst_n;
	logic [31:0] hdr_ff;
	logic [31:0] opt_ff;
	logic [31:0] opt_view;
	logic crc_load;
	logic hdr_wr;
	logic opt_wr;

	bib_reg_if rg ();

	// ==========================================================
	// reset release
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
			rst_sync_ff <= 2'h0;
		else
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	end
	assign rst_n = rst_sync_ff[1];

	// ==========================================================
	// register read decode
	function automatic logic [31:0] reg_read(input logic [7:0] a,
		input logic [31:0] hdr, input logic [31:0] optv);
		logic [31:0] d;
		d = bib_pkg::DATA_ZERO;
		case (a)
			bib_pkg::OFS_HDR: d = hdr;
			bib_pkg::OFS_BUSID: d = bib_pkg::BUS_NAME_ID;
			bib_pkg::OFS_OPT: d = optv;
			default: d = bib_pkg::DATA_ZERO;
		endcase
		return d;
	endfunction

	assign opt_view = (opt_ff & bib_pkg::OPT_RW_MASK) | bib_pkg::OPT_LINK_SPEED;
	// decode only while a read is pending; otherwise rg.rdata shows zero
	assign rg.rdata = rg.rd ? reg_read(rg.addr, hdr_ff, opt_view)
		: bib_pkg::DATA_ZERO;

	assign hdr_wr = rg.wr && rg.addr == bib_pkg::OFS_HDR;
	assign opt_wr = rg.wr && rg.addr == bib_pkg::OFS_OPT;
	assign crc_load = srom_present_i && srom_crc_valid_i;

	// ==========================================================
	// header quadlet
	always_ff @(posedge clock_i or negedge rst_n)
	begin
		if (!rst_n)
			hdr_ff <= bib_pkg::HDR_RESET;
		else
		begin
			if (hdr_wr)
				hdr_ff <= rg.wdata;
			// serial ROM checksum wins over a same-cycle host write
			if (crc_load)
				hdr_ff[bib_pkg::HDR_CRC_MSB:bib_pkg::HDR_CRC_LSB] <= srom_crc_i;
		end
	end

	// ==========================================================
	// bus options quadlet
	always_ff @(posedge clock_i or negedge rst_n)
	begin
		if (!rst_n)
			opt_ff <= bib_pkg::OPT_RESET;
		else if (opt_wr)
			// only writable fields take the write
			opt_ff <= rg.wdata & bib_pkg::OPT_RW_MASK;
	end

	// ==========================================================
	// bus slave and remote view
	bib_ahb_slave u_ahb
	(
		.clock_i(clock_i),
		.rst_n_i(rst_n),
		.hsel_i(hsel_i),
		.haddr_i(haddr_i),
		.htrans_i(htrans_i),
		.hwrite_i(hwrite_i),
		.hsize_i(hsize_i),
		.hwdata_i(hwdata_i),
		.hready_i(hready_i),
		.hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o),
		.hresp_o(hresp_o),
		.rg(rg.bus_side)
	);

	// answered only while the link is active, when fields are valid
	bib_cfg_port u_cfg
	(
		.clock_i(clock_i),
		.rst_n_i(rst_n),
		.cfg_req_i(cfg_req_i),
		.cfg_addr_i(cfg_addr_i),
		.link_active_i(link_active_i),
		.hdr_i(hdr_ff),
		.opt_i(opt_view),
		.cfg_ack_o(cfg_ack_o),
		.cfg_hit_o(cfg_hit_o),
		.cfg_data_o(cfg_data_o)
	);

	// ==========================================================
	// checks
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_n);

	logic rd_acc;
	assign rd_acc = hsel_i && htrans_i[1] && hready_i && !hwrite_i
		&& hsize_i == bib_pkg::HSIZE_WORD;

	AST_CFG_HDR: assert property (
		cfg_req_i && link_active_i && cfg_addr_i == bib_pkg::CFG_ROM_BASE
		|=> cfg_ack_o && cfg_hit_o && cfg_data_o == $past(hdr_ff))
		else $error("header quadlet not served to remote node");

	AST_HDR_WRITE: assert property (
		hdr_wr && !crc_load |=> hdr_ff == $past(rg.wdata))
		else $error("header write not stored");

	AST_CRC_LOAD: assert property (
		crc_load |=> hdr_ff[15:0] == $past(srom_crc_i))
		else $error("serial ROM checksum not loaded");

	AST_CRC_UPPER: assert property (
		crc_load && !hdr_wr |=> $stable(hdr_ff[31:16]))
		else $error("checksum load disturbed upper header");

	AST_BUSID_READ: assert property (
		rd_acc && haddr_i[7:0] == bib_pkg::OFS_BUSID
		|=> !hreadyout_o ##1 hreadyout_o && hrdata_o == bib_pkg::BUS_NAME_ID)
		else $error("bus name read wrong");

	AST_CFG_OPT: assert property (
		cfg_req_i && link_active_i && cfg_addr_i == bib_pkg::CFG_OPT_ADDR
		|=> cfg_data_o == $past(opt_view))
		else $error("options quadlet not served to remote node");

	AST_OPT_FLAGS: assert property (
		opt_wr |=> opt_ff[31:29] == $past(rg.wdata[31:29]))
		else $error("capability flags not written");

	AST_LINK_SPEED: assert property (
		rd_acc && haddr_i[7:0] == bib_pkg::OFS_OPT
		|=> ##1 hrdata_o[2:0] == bib_pkg::LINK_SPEED_CODE
		&& hrdata_o[26:24] == 3'h0)
		else $error("link speed field wrong");

	AST_RO_IGNORED: assert property (
		rg.wr && rg.addr != bib_pkg::OFS_HDR && rg.addr != bib_pkg::OFS_OPT
		&& !crc_load
		|=> $stable(hdr_ff) && $stable(opt_ff))
		else $error("write to read-only location changed state");

	AST_NO_LINK: assert property (
		!link_active_i |=> !cfg_ack_o)
		else $error("remote answer while link inactive");

	// ==========================================================
	// read path, hold and remote-view checks
	AST_HDR_READ: assert property (
		rd_acc && haddr_i[7:0] == bib_pkg::OFS_HDR
		|=> ##1 hreadyout_o && hrdata_o == $past(hdr_ff))
		else $error("header read wrong");

	AST_OPT_READ: assert property (
		rd_acc && haddr_i[7:0] == bib_pkg::OFS_OPT
		|=> ##1 hreadyout_o && hrdata_o == $past(opt_view))
		else $error("options read wrong");

	AST_IRMC_READ: assert property (
		rd_acc && haddr_i[7:0] == bib_pkg::OFS_OPT
		|=> ##1 hrdata_o[bib_pkg::OPT_IRMC_BIT]
		== $past(opt_ff[bib_pkg::OPT_IRMC_BIT]))
		else $error("resource manager flag read wrong");

	AST_CMC_READ: assert property (
		rd_acc && haddr_i[7:0] == bib_pkg::OFS_OPT
		|=> ##1 hrdata_o[bib_pkg::OPT_CMC_BIT]
		== $past(opt_ff[bib_pkg::OPT_CMC_BIT]))
		else $error("cycle master flag read wrong");

	AST_ISC_READ: assert property (
		rd_acc && haddr_i[7:0] == bib_pkg::OFS_OPT
		|=> ##1 hrdata_o[bib_pkg::OPT_ISC_BIT]
		== $past(opt_ff[bib_pkg::OPT_ISC_BIT]))
		else $error("isochronous flag read wrong");

	AST_READ_WAIT: assert property (
		rd_acc |=> !hreadyout_o ##1 hreadyout_o)
		else $error("read wait state wrong");

	AST_WRITE_NO_WAIT: assert property (
		hsel_i && htrans_i[1] && hready_i && hwrite_i |=> hreadyout_o)
		else $error("write data phase stalled");

	AST_HDR_HOLD: assert property (
		!hdr_wr && !crc_load |=> $stable(hdr_ff))
		else $error("header changed without a write");

	AST_RDATA_HOLD: assert property (
		!rg.rd |=> $stable(hrdata_o))
		else $error("read data changed without a read");

	AST_CRC_NEEDS_ROM: assert property (
		srom_crc_valid_i && !srom_present_i && !hdr_wr
		|=> $stable(hdr_ff))
		else $error("checksum loaded with no serial ROM");

	AST_CRC_WITH_WRITE: assert property (
		hdr_wr && crc_load
		|=> hdr_ff == {$past(rg.wdata[31:16]), $past(srom_crc_i)})
		else $error("same-cycle write and checksum load mixed up");

	AST_CFG_BUSID: assert property (
		cfg_req_i && link_active_i && cfg_addr_i == bib_pkg::CFG_BUSID_ADDR
		|=> cfg_ack_o && cfg_hit_o && cfg_data_o == bib_pkg::BUS_NAME_ID)
		else $error("bus name quadlet not served to remote node");

	AST_CFG_MISS: assert property (
		cfg_req_i && link_active_i && cfg_addr_i != bib_pkg::CFG_ROM_BASE
		&& cfg_addr_i != bib_pkg::CFG_BUSID_ADDR
		&& cfg_addr_i != bib_pkg::CFG_OPT_ADDR
		|=> cfg_ack_o && !cfg_hit_o)
		else $error("unmapped remote address reported as hit");

	AST_HIT_WITH_ACK: assert property (
		cfg_hit_o |-> cfg_ack_o)
		else $error("remote hit without answer");

	AST_NO_REQ_NO_ACK: assert property (
		!cfg_req_i |=> !cfg_ack_o)
		else $error("remote answer without request");

	AST_CFG_DATA_HOLD: assert property (
		!(cfg_req_i && link_active_i) |=> $stable(cfg_data_o))
		else $error("remote data changed without an answer");

	AST_OPT_HOLD: assert property (
		!opt_wr |=> $stable(opt_ff))
		else $error("options changed without a write");

	AST_OPT_RO_WRITE: assert property (
		opt_wr |=> (opt_ff & ~bib_pkg::OPT_RW_MASK) == bib_pkg::DATA_ZERO)
		else $error("write reached read-only option bits");

	COV_CFG_HDR: cover property (
		cfg_req_i && link_active_i && cfg_addr_i == bib_pkg::CFG_ROM_BASE);
	COV_OPT_WRITE: cover property (opt_wr);
	COV_LINK_DOWN: cover property (cfg_req_i && !link_active_i);
	COV_CRC_LOAD: cover property (crc_load ##1 hdr_wr);
	COV_HDR_READ: cover property (
		rd_acc && haddr_i[7:0] == bib_pkg::OFS_HDR);
endmodule

//--- core/bib_pkg.sv
// constants shared by the bus information block register files
package bib_pkg;

	// ==========================================================
	// register map (byte addresses on the register bus)
	localparam int REG_AW = 8;
	localparam logic [7:0] OFS_HDR = 8'h18;
	localparam logic [7:0] OFS_BUSID = 8'h1c;
	localparam logic [7:0] OFS_OPT = 8'h20;

	// ==========================================================
	// field layout and reset values
	localparam logic [31:0] BUS_NAME_ID = 32'h31333934;
	localparam logic [31:0] HDR_RESET = 32'h00000000;
	localparam int HDR_CRC_LSB = 0;
	localparam int HDR_CRC_MSB = 15;
	localparam int HDR_UPPER_LSB = 16;
	// writable bits: irmc cmc isc bmc pmc, clock accuracy, max_rec, g
	localparam logic [31:0] OPT_RW_MASK = 32'hf8fff0c0;
	localparam logic [31:0] OPT_RESET = 32'h0000a000;
	localparam logic [31:0] OPT_LINK_SPEED = 32'h00000002;
	localparam int OPT_IRMC_BIT = 31;
	localparam int OPT_CMC_BIT = 30;
	localparam int OPT_ISC_BIT = 29;
	localparam logic [2:0] LINK_SPEED_CODE = 3'h2;

	// ==========================================================
	// remote configuration ROM view
	localparam logic [47:0] CFG_ROM_BASE = 48'hfffff0000400;
	localparam logic [47:0] CFG_BUSID_ADDR = 48'hfffff0000404;
	localparam logic [47:0] CFG_OPT_ADDR = 48'hfffff0000408;

	// ==========================================================
	// bus encodings
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic HRESP_OKAY = 1'h0;
	localparam logic [31:0] DATA_ZERO = 32'h00000000;

endpackage

//--- core/bib_reg_if.sv
// carrier between the bus slave and the register bank
`timescale 1ns/10ps
interface bib_reg_if;
	logic wr;
	logic rd;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;

	modport bus_side
	(
		output wr,
		output rd,
		output addr,
		output wdata,
		input rdata
	);
	modport reg_side
	(
		input wr,
		input rd,
		input addr,
		input wdata,
		output rdata
	);
endinterface

//--- core/bib_ahb_slave.sv
// ahb-lite slave front end: zero-wait writes, one-wait reads
`timescale 1ns/10ps
module bib_ahb_slave
(
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	bib_reg_if.bus_side rg
);
	logic acc;
	logic wr_pend_ff;
	logic rd_pend_ff;
	logic [7:0] addr_ff;
	logic rdy_ff;
	logic [31:0] rdata_ff;
	logic resp_ff;

	// only whole-word transfers are taken; others complete with no effect
	assign acc = hsel_i && htrans_i[1] && hready_i
		&& hsize_i == bib_pkg::HSIZE_WORD;

	// ==========================================================
	// address phase capture
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wr_pend_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
			addr_ff <= 8'h00;
		end
		else
		begin
			wr_pend_ff <= acc && hwrite_i;
			rd_pend_ff <= acc && !hwrite_i;
			if (acc)
				addr_ff <= haddr_i[7:0];
		end
	end

	// ==========================================================
	// read data phase: the wait cycle lets a preceding write land first
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rdy_ff <= 1'b1;
			rdata_ff <= bib_pkg::DATA_ZERO;
			resp_ff <= bib_pkg::HRESP_OKAY;
		end
		else
		begin
			resp_ff <= bib_pkg::HRESP_OKAY;
			if (acc && !hwrite_i)
				rdy_ff <= 1'b0;
			else if (rd_pend_ff)
				rdy_ff <= 1'b1;
			if (rd_pend_ff)
				rdata_ff <= rg.rdata;
		end
	end

	assign rg.wr = wr_pend_ff;
	assign rg.rd = rd_pend_ff;
	assign rg.addr = addr_ff;
	assign rg.wdata = hwdata_i;
	assign hrdata_o = rdata_ff;
	assign hreadyout_o = rdy_ff;
	assign hresp_o = resp_ff;
endmodule

//--- core/bib_cfg_port.sv
// remote-node view of the first three configuration ROM quadlets
`timescale 1ns/10ps
module bib_cfg_port
(
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic cfg_req_i,
	input wire logic [47:0] cfg_addr_i,
	input wire logic link_active_i,
	input wire logic [31:0] hdr_i,
	input wire logic [31:0] opt_i,
	output logic cfg_ack_o,
	output logic cfg_hit_o,
	output logic [31:0] cfg_data_o
);
	logic ack_ff;
	logic hit_ff;
	logic [31:0] data_ff;
	logic [31:0] sel_data;
	logic sel_hit;

	always_comb
	begin
		sel_hit = 1'b1;
		case (cfg_addr_i)
			bib_pkg::CFG_ROM_BASE: sel_data = hdr_i;
			bib_pkg::CFG_BUSID_ADDR: sel_data = bib_pkg::BUS_NAME_ID;
			bib_pkg::CFG_OPT_ADDR: sel_data = opt_i;
			default:
			begin
				sel_data = bib_pkg::DATA_ZERO;
				sel_hit = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// answer one cycle after the request; no answer while link is down
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ack_ff <= 1'b0;
			hit_ff <= 1'b0;
			data_ff <= bib_pkg::DATA_ZERO;
		end
		else
		begin
			ack_ff <= cfg_req_i && link_active_i;
			hit_ff <= cfg_req_i && link_active_i && sel_hit;
			if (cfg_req_i && link_active_i)
				data_ff <= sel_data;
		end
	end

	assign cfg_ack_o = ack_ff;
	assign cfg_hit_o = hit_ff;
	assign cfg_data_o = data_ff;
endmodule

//--- verification/bib_remote_node.sv
// remote bus node model that reads configuration rom quadlets
`timescale 1ns/10ps
module bib_remote_node
(
	input wire logic clock_i,
	input wire logic cfg_ack_i,
	input wire logic cfg_hit_i,
	input wire logic [31:0] cfg_data_i,
	output logic cfg_req_o,
	output logic [47:0] cfg_addr_o
);
	initial
	begin
		cfg_req_o = 1'h0;
		cfg_addr_o = 48'h0;
	end

	// ==========================================================
	// one quadlet read; gap idles first so a node can ask late
	task read_quad(input logic [47:0] a, input int gap,
		output logic ack, output logic hit, output logic [31:0] d);
		repeat (gap) @(posedge clock_i);
		cfg_req_o <= 1'h1;
		cfg_addr_o <= a;
		@(posedge clock_i);
		cfg_req_o <= 1'h0;
		// a released address must not keep showing the old value
		cfg_addr_o <= ~a;
		@(posedge clock_i);
		ack = cfg_ack_i;
		hit = cfg_hit_i;
		d = cfg_data_i;
	endtask
endmodule

//--- verification/test_bus_info_block_registers.sv
// self-checking bench for the bus information block registers
`timescale 1ns/10ps
module test_bus_info_block_registers;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic hsel = 1'h0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'h0;
	logic [2:0] hsize = bib_pkg::HSIZE_WORD;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hready;
	logic hresp;
	logic srom_on = 1'h0;
	logic srom_vld = 1'h0;
	logic [15:0] srom_crc = 16'h0;
	logic link_on = 1'h0;
	logic cfg_req;
	logic [47:0] cfg_addr;
	logic cfg_ack;
	logic cfg_hit;
	logic [31:0] cfg_data;
	logic [31:0] d;
	logic [31:0] v;
	logic ak;
	logic ht;
	int n_fail = 0;
	int n_tests = 0;
	int cyc = 0;

	always #12.5 clk = ~clk;

	bib_regs dut (.clock_i(clk), .resetn_i(rst_n), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
		.hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
		.srom_present_i(srom_on), .srom_crc_valid_i(srom_vld),
		.srom_crc_i(srom_crc), .link_active_i(link_on),
		.cfg_req_i(cfg_req), .cfg_addr_i(cfg_addr), .cfg_ack_o(cfg_ack),
		.cfg_hit_o(cfg_hit), .cfg_data_o(cfg_data));

	bib_remote_node rn (.clock_i(clk), .cfg_ack_i(cfg_ack),
		.cfg_hit_i(cfg_hit), .cfg_data_i(cfg_data), .cfg_req_o(cfg_req),
		.cfg_addr_o(cfg_addr));

	// ==========================================================
	// checking and closing
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task end_sim;
		$display("tests=%0d failures=%0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// whole test is well under this many cycles
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			n_fail++;
			end_sim;
		end
	end

	// ==========================================================
	// single word transfer; waits on hready in both phases
	task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'h1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hready !== 1'h1);
		rd = hrdata;
	endtask

	// ==========================================================
	// main sequence
	initial
	begin
		repeat (4) @(posedge clk);
		rst_n <= 1'h1;
		repeat (3) @(posedge clk);
		ahb(1'h0, 32'h18, 32'h0, d);
		chk(d & 32'hffff0000, 32'h0);
		ahb(1'h0, 32'h1c, 32'h0, d);
		chk(d, bib_pkg::BUS_NAME_ID);
		ahb(1'h1, 32'h1c, 32'h0, d);
		ahb(1'h0, 32'h1c, 32'h0, d);
		chk(d, bib_pkg::BUS_NAME_ID);
		ahb(1'h0, 32'h20, 32'h0, d);
		chk(d & 32'h7, 32'h2);
		// one capability bit at a time; read-only speed bits written as 1
		for (int b = 28; b < 32; b++)
		begin
			v = (32'h1 << b) | 32'h7;
			ahb(1'h1, 32'h20, v, d);
			ahb(1'h0, 32'h20, 32'h0, d);
			// bits 31..27 writable, speed bits always read 010
			chk(d, (v & 32'hf8000000) | 32'h2);
		end
		ahb(1'h1, 32'h18, 32'h0414a5c3, d);
		ahb(1'h0, 32'h18, 32'h0, d);
		chk(d, 32'h0414a5c3);
		// a checksum strobe with no serial ROM must not load
		srom_crc <= 16'hdead;
		srom_vld <= 1'h1;
		@(posedge clk);
		srom_on <= 1'h1;
		srom_crc <= 16'hbeef;
		@(posedge clk);
		srom_vld <= 1'h0;
		ahb(1'h0, 32'h18, 32'h0, d);
		chk(d, 32'h0414beef);
		// header and options are set before the link goes active
		link_on <= 1'h1;
		@(posedge clk);
		rn.read_quad(48'hfffff0000400, 0, ak, ht, d);
		chk({ak, ht}, 32'h3);
		chk(d, 32'h0414beef);
		rn.read_quad(48'hfffff0000404, 2, ak, ht, d);
		chk(d, bib_pkg::BUS_NAME_ID);
		rn.read_quad(48'hfffff0000408, 0, ak, ht, d);
		chk(d, 32'h80000002);
		rn.read_quad(48'hfffff000040c, 0, ak, ht, d);
		chk({ak, ht}, 32'h2);
		link_on <= 1'h0;
		@(posedge clk);
		rn.read_quad(48'hfffff0000400, 0, ak, ht, d);
		chk(ak, 32'h0);
		ahb(1'h1, 32'h40, 32'hffffffff, d);
		ahb(1'h0, 32'h40, 32'h0, d);
		chk(d, 32'h0);
		chk(hresp, bib_pkg::HRESP_OKAY);
		// a second reset brings the upper header half back to zero
		rst_n <= 1'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		repeat (3) @(posedge clk);
		ahb(1'h0, 32'h18, 32'h0, d);
		chk(d & 32'hffff0000, 32'h0);
		end_sim;
	end
endmodule
